/* pkg/vpm_pkg.sv */
/*
 Constants for the vector pop-count, mask and memory datapath.
 Assumes a 64-bit word, 64-element vector registers and a word-addressed memory.
*/
// Function
// - Pop-count opcode writes the number of one bits of each source element.
// - Parity opcode writes 0 for an even count of ones, 1 for odd.
// - Pop-count and parity process vector_length elements starting at element zero.
// - The vector mask is 64 bits, one bit per element.
// - Low opcode field selects test: 0 zero, 1 nonzero, 2 positive, 3 negative.
// - Each tested element sets its mask bit when the test holds, else clears it.
// - Mask is cleared first, then only vector_length elements are tested.
// - A zero element counts as positive and not as negative.
// - Mask bits number from the left: element zero is the leftmost bit.
// - Variants 4 to 7 also write a compressed index list to the result register.
// - Mask and compressed-index work is done in the vector logical unit.
// - Strided load starts at the base address and adds the stride per word.
// - The stride is signed; negative strides walk memory backward.
// - A stride designator of zero means a stride of one.
// - Strided store writes successive source elements from base, adding signed stride.
// - Gather address is base plus sign-extended low 24 bits of the index element.
// - Scatter address is base plus sign-extended low 24 bits of the index element.
// - A vector load moves exactly vector_length words.
`default_nettype none
package vpm_pkg;
   localparam int WORD_W  = 64;
   localparam int ELEMS   = 64;
   localparam int IDX_W   = 6;
   localparam int VLEN_W  = 7;
   localparam int ADDR_W  = 24;
   localparam int REG_W   = 3;
   localparam int OFFS_W  = 24;
   localparam int CNT_W   = 7;
   typedef enum logic [3:0] {
      OP_POP   = 4'h0,
      OP_PAR   = 4'h1,
      OP_MASK  = 4'h2,
      OP_LOAD  = 4'h3,
      OP_STORE = 4'h4,
      OP_GATH  = 4'h5,
      OP_SCAT  = 4'h6
   } vpm_op_e;
   localparam logic [1:0] TEST_ZERO = 2'h0;
   localparam logic [1:0] TEST_NZ   = 2'h1;
   localparam logic [1:0] TEST_POS  = 2'h2;
   localparam logic [1:0] TEST_NEG  = 2'h3;
endpackage
`default_nettype wire

/* verilog/vpm_elem_unit.sv */
/*
 Per-element combinational helper: population count, parity and the zero,
 nonzero, positive and negative test of one 64-bit element.
 Assumes its user registers the results.
*/
`timescale 1ns/100ps
`default_nettype none
module vpm_elem_unit (
   input  wire logic [vpm_pkg::WORD_W-1:0] elem,
   input  wire logic [1:0]                 test_sel,
   output logic      [vpm_pkg::CNT_W-1:0]  pop,
   output logic                            par,
   output logic                            hit
);
   always_comb begin
      pop = '0;
      for (int b = 0; b < vpm_pkg::WORD_W; b++) begin
         pop = pop + vpm_pkg::CNT_W'(elem[b]);
      end
      par = ^elem;
      case (test_sel)
         vpm_pkg::TEST_ZERO: hit = (elem == '0);
         vpm_pkg::TEST_NZ:   hit = (elem != '0);
         vpm_pkg::TEST_POS:  hit = ~elem[vpm_pkg::WORD_W-1];
         default:            hit = elem[vpm_pkg::WORD_W-1];
      endcase
   end
endmodule
`default_nettype wire

/* verilog/vpm_top.sv */
/*
 Vector logical and memory datapath: pop count and parity, mask generation
 with optional compressed index list, and strided, gather and scatter
 transfers between eight 64-element vector registers and main memory.
 Assumes a memory that takes one word request per cycle when mem_ready is
 high and returns read data with mem_rvalid, in request order.
*/
`timescale 1ns/100ps
`default_nettype none
module vpm_top (
   input  wire logic                        clock,
   input  wire logic                        nrst,
   input  wire logic                        clk_en,
   input  wire logic                        start,
   input  wire logic [3:0]                  opcode,
   input  wire logic [1:0]                  test_sel,
   input  wire logic                        compress,
   input  wire logic [vpm_pkg::REG_W-1:0]   result_sel,
   input  wire logic [vpm_pkg::REG_W-1:0]   source_sel,
   input  wire logic [vpm_pkg::REG_W-1:0]   index_sel,
   input  wire logic                        stride_zero,
   input  wire logic [vpm_pkg::VLEN_W-1:0]  vector_length,
   input  wire logic [vpm_pkg::ADDR_W-1:0]  base_address_register,
   input  wire logic [vpm_pkg::ADDR_W-1:0]  stride_register,
   input  wire logic                        mem_ready,
   input  wire logic                        mem_rvalid,
   input  wire logic [vpm_pkg::WORD_W-1:0]  mem_rdata,
   output logic                             busy,
   output logic                             done,
   output logic      [vpm_pkg::ELEMS-1:0]   vector_mask,
   output logic                             mem_req,
   output logic                             mem_we,
   output logic      [vpm_pkg::ADDR_W-1:0]  mem_addr,
   output logic      [vpm_pkg::WORD_W-1:0]  mem_wdata
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ALU  = 4'b0010,
      ST_MEM  = 4'b0100,
      ST_WAIT = 4'b1000
   } vpm_state_e;

   logic [vpm_pkg::WORD_W-1:0] vreg [8][vpm_pkg::ELEMS];
   vpm_state_e                 state;
   logic [3:0]                 op;
   logic [1:0]                 tsel;
   logic                       cmp;
   logic [vpm_pkg::REG_W-1:0]  ri;
   logic [vpm_pkg::REG_W-1:0]  rj;
   logic [vpm_pkg::REG_W-1:0]  rk;
   logic [vpm_pkg::VLEN_W-1:0] vlen;
   logic [vpm_pkg::ADDR_W-1:0] base;
   logic [vpm_pkg::ADDR_W-1:0] stride;
   logic [vpm_pkg::ADDR_W-1:0] cur_addr;
   logic [vpm_pkg::VLEN_W-1:0] elem;
   logic [vpm_pkg::VLEN_W-1:0] rcv;
   logic [vpm_pkg::VLEN_W-1:0] cidx;
   logic [vpm_pkg::WORD_W-1:0] src_word;
   logic [vpm_pkg::WORD_W-1:0] idx_word;
   logic [vpm_pkg::CNT_W-1:0]  pop;
   logic                       par;
   logic                       hit;
   logic                       last_issue;
   logic [vpm_pkg::ADDR_W-1:0] next_addr;
   logic [vpm_pkg::ADDR_W-1:0] gather_addr;
   logic                       rd_pin_q1;
   logic                       rd_pin_q2;

   // Sign-extends the low 24 bits of an index element into an address offset.
   function automatic logic [vpm_pkg::ADDR_W-1:0] offs(input logic [vpm_pkg::WORD_W-1:0] w);
      offs = vpm_pkg::ADDR_W'(w[vpm_pkg::OFFS_W-1:0]);
   endfunction

   function automatic logic is_mem_op(input logic [3:0] o);
      is_mem_op = (o == vpm_pkg::OP_LOAD) || (o == vpm_pkg::OP_STORE) ||
                  (o == vpm_pkg::OP_GATH) || (o == vpm_pkg::OP_SCAT);
   endfunction

   assign src_word   = vreg[rj][elem[vpm_pkg::IDX_W-1:0]];
   assign idx_word   = vreg[rk][elem[vpm_pkg::IDX_W-1:0]];
   assign last_issue = (elem + 7'h01 >= vlen);
   assign next_addr  = cur_addr + stride;
   assign gather_addr = base + offs(idx_word);

   vpm_elem_unit u_elem (
      .elem     (src_word),
      .test_sel (tsel),
      .pop      (pop),
      .par      (par),
      .hit      (hit)
   );

   // Memory handshake from a different domain is brought in by two flops.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rd_pin_q1 <= 1'b0;
         rd_pin_q2 <= 1'b0;
      end else if (clk_en) begin
         rd_pin_q1 <= mem_ready;
         rd_pin_q2 <= rd_pin_q1;
      end
   end

   // Command capture and sequencing.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state  <= ST_IDLE;
         op     <= 4'h0;
         tsel   <= 2'h0;
         cmp    <= 1'b0;
         ri     <= '0;
         rj     <= '0;
         rk     <= '0;
         vlen   <= '0;
         base   <= '0;
         stride <= '0;
         elem   <= '0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start) begin
                  op     <= opcode;
                  tsel   <= test_sel;
                  cmp    <= compress;
                  ri     <= result_sel;
                  rj     <= source_sel;
                  rk     <= index_sel;
                  vlen   <= vector_length;
                  base   <= base_address_register;
                  stride <= stride_zero ? 24'h000001 : stride_register;
                  elem   <= '0;
                  busy   <= 1'b1;
                  if (vector_length == '0) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                  end else if (is_mem_op(opcode)) begin
                     state <= ST_MEM;
                  end else begin
                     state <= ST_ALU;
                  end
               end
            end
            ST_ALU: begin
               elem <= elem + 7'h01;
               if (last_issue) begin
                  state <= ST_IDLE;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end
            end
            ST_MEM: begin
               if (rd_pin_q2) begin
                  elem <= elem + 7'h01;
                  if (last_issue) begin
                     if ((op == vpm_pkg::OP_LOAD) || (op == vpm_pkg::OP_GATH)) begin
                        state <= ST_WAIT;
                     end else begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (mem_rvalid && (rcv + 7'h01 >= vlen)) begin
                  state <= ST_IDLE;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   // Memory request issue; strided address walks, indexed address is rebuilt per element.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= '0;
         cur_addr  <= '0;
      end else if (clk_en) begin
         mem_req <= 1'b0;
         if (state == ST_IDLE && start) begin
            cur_addr <= base_address_register;
         end else if (state == ST_MEM && rd_pin_q2) begin
            mem_req   <= 1'b1;
            mem_we    <= (op == vpm_pkg::OP_STORE) || (op == vpm_pkg::OP_SCAT);
            mem_wdata <= src_word;
            if ((op == vpm_pkg::OP_GATH) || (op == vpm_pkg::OP_SCAT)) begin
               mem_addr <= gather_addr;
            end else begin
               mem_addr <= cur_addr;
               cur_addr <= next_addr;
            end
         end
      end
   end

   // Mask register: cleared at start, one bit per tested element.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         vector_mask <= '0;
      end else if (clk_en) begin
         if (state == ST_IDLE && start && opcode == vpm_pkg::OP_MASK) begin
            vector_mask <= '0;
         end else if (state == ST_ALU && op == vpm_pkg::OP_MASK) begin
            vector_mask[vpm_pkg::ELEMS-1-elem[vpm_pkg::IDX_W-1:0]] <= hit;
         end
      end
   end

   // Vector register writes; elements past the length are never addressed.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rcv  <= '0;
         cidx <= '0;
      end else if (clk_en) begin
         if (state == ST_IDLE && start) begin
            rcv  <= '0;
            cidx <= '0;
         end else if (state == ST_ALU) begin
            case (op)
               vpm_pkg::OP_POP: begin
                  vreg[ri][elem[vpm_pkg::IDX_W-1:0]] <= 64'(pop);
               end
               vpm_pkg::OP_PAR: begin
                  vreg[ri][elem[vpm_pkg::IDX_W-1:0]] <= 64'(par);
               end
               vpm_pkg::OP_MASK: begin
                  if (cmp && hit) begin
                     vreg[ri][cidx[vpm_pkg::IDX_W-1:0]] <= 64'(elem);
                     cidx <= cidx + 7'h01;
                  end
               end
               default: begin
                  cidx <= cidx;
               end
            endcase
         end else if ((state == ST_MEM || state == ST_WAIT) && mem_rvalid &&
                      rcv < vlen) begin
            vreg[ri][rcv[vpm_pkg::IDX_W-1:0]] <= mem_rdata;
            rcv <= rcv + 7'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/vpm_top_sva.sv */
/*
 Checker bound to vpm_top: command timing, mask write order and memory addressing.
 Assumes clk_en stays high while a command runs.
*/
`timescale 1ns/100ps
`default_nettype none
module vpm_top_sva (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        clk_en,
   input wire logic        start,
   input wire logic [3:0]  opcode,
   input wire logic        stride_zero,
   input wire logic [6:0]  vector_length,
   input wire logic [23:0] base_address_register,
   input wire logic [23:0] stride_register,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [63:0] vector_mask,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [23:0] mem_addr
);
   logic        take, alu, msk, strd, wr;
   logic [7:0]  cnt, reqs;
   logic [6:0]  len_l;
   logic [23:0] base_l, step_l, prev;
   assign take = clk_en && start && !busy;
   // The cycle count is one in the first cycle after a command is taken.
   always_ff @(posedge clock) begin
      if (!nrst || take) begin
         cnt  <= 8'h1;
         reqs <= 8'h0;
      end else begin
         cnt  <= cnt + 8'h1;
         reqs <= reqs + {7'h0, mem_req};
      end
   end
   always_ff @(posedge clock) begin
      if (take) begin
         alu    <= opcode < 4'h3;
         msk    <= opcode == vpm_pkg::OP_MASK;
         strd   <= opcode == vpm_pkg::OP_LOAD || opcode == vpm_pkg::OP_STORE;
         wr     <= opcode == vpm_pkg::OP_STORE || opcode == vpm_pkg::OP_SCAT;
         len_l  <= vector_length;
         base_l <= base_address_register;
         step_l <= stride_zero ? 24'h1 : stride_register;
      end
   end
   always_ff @(posedge clock) begin
      if (mem_req)
         prev <= mem_addr;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   mask_clear_a: assert property (
      take && opcode == vpm_pkg::OP_MASK |=> vector_mask == 64'h0)
      else $error("mask not cleared at start");
   mask_order_a: assert property (
      (busy || done) && msk && cnt > 8'h1 |->
      ((vector_mask ^ $past(vector_mask)) & ~(64'h1 << (8'd65 - cnt))) == 64'h0)
      else $error("mask bit written out of order");
   mask_hold_a: assert property (
      $changed(vector_mask) |-> (busy || done) && msk)
      else $error("mask changed outside a mask command");
   alu_time_a: assert property (
      done && alu |-> cnt == {1'b0, len_l} + 8'h1)
      else $error("element operation length wrong");
   busy_set_a: assert property (
      take && vector_length != 7'h0 |=> busy && !done)
      else $error("busy not raised for a running command");
   req_count_a: assert property (
      done && !alu |-> reqs + {7'h0, mem_req} == {1'b0, len_l})
      else $error("memory word count wrong");
   first_addr_a: assert property (
      mem_req && strd && reqs == 8'h0 |-> mem_addr == base_l)
      else $error("first address not base");
   stride_step_a: assert property (
      mem_req && strd && reqs != 8'h0 |-> mem_addr == prev + step_l)
      else $error("address step not stride");
   req_kind_a: assert property (
      mem_req |-> (busy || done) && !alu && mem_we == wr)
      else $error("memory request of wrong kind");
   mask_c: cover property (take && opcode == vpm_pkg::OP_MASK);
   wr_c: cover property (mem_req && mem_we);
   alu_c: cover property (done && alu);
endmodule
bind vpm_top vpm_top_sva u_sva (.clock, .nrst, .clk_en, .start, .opcode, .stride_zero,
   .vector_length, .base_address_register, .stride_register, .busy, .done, .vector_mask,
   .mem_req, .mem_we, .mem_addr);
`default_nettype wire

/* dv/vpm_mem_model.sv */
/*
 Word memory on the far side of vpm_top, with random stalls and read delays.
 Assumes requests are single-cycle pulses sampled on the rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module vpm_mem_model (
   input  wire logic        clock,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [63:0] mem_wdata,
   output logic             mem_ready,
   output logic             mem_rvalid,
   output logic      [63:0] mem_rdata
);
   logic [63:0] m [logic [23:0]];
   logic [23:0] rq [$];
   // Unwritten words hold a pattern of their address, with zeros and both signs.
   function automatic logic [63:0] h(logic [23:0] a);
      return (a[2:0] == 3'h0) ? 64'h0 : {a[0], a[23:1], ~a[15:0], a};
   endfunction
   initial begin
      mem_ready  = 1'b0;
      mem_rvalid = 1'b0;
      mem_rdata  = 64'h0;
   end
   // Between words the data lines toggle so stale data is never mistaken for valid.
   always @(posedge clock) begin
      mem_ready <= ($urandom % 4) != 0;
      if (mem_req && mem_we)
         m[mem_addr] = mem_wdata;
      if (mem_req && !mem_we)
         rq.push_back(mem_addr);
      if (rq.size() != 0 && ($urandom % 3) != 0) begin
         mem_rvalid <= 1'b1;
         mem_rdata  <= m.exists(rq[0]) ? m[rq[0]] : h(rq[0]);
         void'(rq.pop_front());
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

/* dv/vector_popcount_mask_memory_bench.sv */
/*
 Self-checking bench for vpm_top with a memory model on its memory port.
 Assumes vector registers start unknown, so each is written before it is stored.
*/
`timescale 1ns/100ps
`default_nettype none
module vector_popcount_mask_memory_bench;
   logic        clock = 1'b0, nrst = 1'b0, start = 1'b0, compress = 1'b0, stride_zero = 1'b0;
   logic        busy, done, mem_req, mem_we, mem_ready, mem_rvalid;
   logic [3:0]  opcode = 4'h0;
   logic [1:0]  test_sel = 2'h0;
   logic [2:0]  result_sel = 3'h0, source_sel = 3'h0, index_sel = 3'h0;
   logic [6:0]  vector_length = 7'h0;
   logic [23:0] base_address_register = 24'h0, stride_register = 24'h0, mem_addr;
   logic [63:0] mem_rdata, mem_wdata, vector_mask;
   logic [63:0] vr [8][64];
   logic [88:0] exq [$];
   logic [63:0] mq [$];
   logic [88:0] e;
   int          failures = 0, cmp_count = 0, k_last, s;
   always #25 clock = ~clock;
   vpm_top dut (.clock, .nrst, .clk_en(1'b1), .start, .opcode, .test_sel, .compress, .result_sel,
      .source_sel, .index_sel, .stride_zero, .vector_length, .base_address_register,
      .stride_register, .mem_ready, .mem_rvalid, .mem_rdata, .busy, .done, .vector_mask,
      .mem_req, .mem_we, .mem_addr, .mem_wdata);
   vpm_mem_model u_mem (.clock, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ready,
      .mem_rvalid, .mem_rdata);
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(string what, logic [88:0] exp, logic [88:0] got);
      cmp_count++;
      if (exp !== got) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic tst(logic [1:0] t, logic [63:0] x);
      case (t)
         2'h0: return x == 64'h0;
         2'h1: return x != 64'h0;
         2'h2: return !x[63];
         default: return x[63];
      endcase
   endfunction
   // Notes the expected requests and results, then runs one command to its done pulse.
   task automatic cmd(logic [3:0] op, logic [1:0] ts, logic cp, logic [2:0] rs, ss, xs,
                      logic sz, logic [6:0] len, logic [23:0] ba, st, logic again = 1'b0);
      logic [23:0] a;
      logic [63:0] m;
      int          n;
      m = 64'h0;
      k_last = 0;
      for (int i = 0; i < len; i++) begin
         a = (op > 4'h4) ? ba + vr[xs][i][23:0] : ba + (sz ? 24'(i) : 24'(i) * st);
         case (op)
            4'h0: vr[rs][i] = 64'($countones(vr[ss][i]));
            4'h1: vr[rs][i] = {63'h0, ^vr[ss][i]};
            4'h2: m[63 - i] = tst(ts, vr[ss][i]);
            4'h3, 4'h5: vr[rs][i] = u_mem.h(a);
            default: ;
         endcase
         if (op == 4'h2 && cp && m[63 - i]) begin
            vr[rs][k_last] = 64'(i);
            k_last++;
         end
         if (op > 4'h2)
            exq.push_back({op[2] & ~op[0], a, op[2] & ~op[0] ? vr[ss][i] : 64'h0});
      end
      if (op == 4'h2)
         mq.push_back(m);
      @(posedge clock);
      {opcode, test_sel, compress, result_sel, source_sel, index_sel, stride_zero, vector_length,
       base_address_register, stride_register, start} <=
         {op, ts, cp, rs, ss, xs, sz, len, ba, st, 1'b1};
      n = 0;
      do begin
         @(posedge clock);
         start <= again && n == 3;
         if (again && n == 3)
            opcode <= 4'h4;
         n++;
      end while (done !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         failures++;
         end_sim();
      end
      @(posedge clock);
      chk("outstanding requests", 89'h0, 89'(exq.size()));
   endtask
   task automatic ld(logic [2:0] r, logic z, logic [6:0] v, logic [23:0] b, st);
      cmd(4'h3, 2'h0, 1'b0, r, 3'h0, 3'h0, z, v, b, st);
   endtask
   task automatic sto(logic [2:0] r, logic [6:0] v, logic [23:0] b);
      cmd(4'h4, 2'h0, 1'b0, 3'h0, r, 3'h0, 1'b1, v, b, 24'h5);
   endtask
   always @(posedge clock) begin
      if (nrst && mem_req) begin
         e = exq.size() != 0 ? exq.pop_front() : 'x;
         chk("memory request", e, {mem_we, mem_addr, mem_we ? mem_wdata : e[63:0]});
      end
      if (nrst && done && mq.size() != 0)
         chk("vector mask", 89'(mq.pop_front()), 89'(vector_mask));
   end
   initial begin
      s = $urandom(16);
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      ld(3'h0, 1'b1, 7'd64, 24'h000100, 24'h7);
      ld(3'h1, 1'b0, 7'd64, 24'h010000, 24'hfffffd);
      ld(3'h1, 1'b0, 7'd5, 24'h020000, 24'(($urandom % 7) + 2));
      ld(3'h4, 1'b1, 7'd16, 24'hfffff0, 24'h0);
      cmd(4'h0, 2'h0, 1'b0, 3'h2, 3'h0, 3'h0, 1'b0, 7'd64, 24'h0, 24'h0, 1'b1);
      sto(3'h2, 7'd64, 24'h050000);
      cmd(4'h1, 2'h0, 1'b0, 3'h2, 3'h1, 3'h0, 1'b0, 7'd40, 24'h0, 24'h0);
      sto(3'h2, 7'd64, 24'h050100);
      sto(3'h1, 7'd64, 24'h050200);
      cmd(4'h5, 2'h0, 1'b0, 3'h5, 3'h0, 3'h4, 1'b0, 7'd16, 24'h030000, 24'h0);
      sto(3'h5, 7'd16, 24'h050300);
      cmd(4'h6, 2'h0, 1'b0, 3'h0, 3'h2, 3'h4, 1'b0, 7'd16, 24'h040000, 24'h0);
      for (int t = 0; t < 8; t++) begin
         cmd(4'h2, 2'(t), t[2], 3'h3, 3'(t % 2), 3'h0, 1'b0, 7'($urandom % 65), 24'h0,
             24'h0);
         if (t[2])
            sto(3'h3, 7'(k_last), 24'h070000 + 24'(t * 256));
      end
      cmd(4'h4, 2'h0, 1'b0, 3'h0, 3'h0, 3'h0, 1'b0, 7'd64, 24'h060000, 24'($urandom));
      end_sim();
   end
endmodule
`default_nettype wire
